//--- hdl/eclsm_delay.sv
`timescale 1ns/100ps
module eclsm_delay #(
	parameter int CNT_W = 32
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Control
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] length,
	output logic                  busy,
	output logic                  done
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             busy;
		logic             done;
	} eclsm_dly_st_t;

	eclsm_dly_st_t st_ff;
	eclsm_dly_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (start) begin
			nxt_st.cnt = length;
			nxt_st.busy = 1'b1;
		end else if (st_ff.busy) begin
			if (st_ff.cnt == '0) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy = st_ff.busy;
	assign done = st_ff.done;
endmodule : eclsm_delay

//--- hdl/eclsm_pkg.sv
package eclsm_pkg;
	// Quadrature and microstep figures
	localparam int          COUNTS_PER_LINE   = 4;
	localparam int          ENC_LINES         = 1000;
	localparam int          COUNTS_PER_REV    = COUNTS_PER_LINE * ENC_LINES;
	localparam logic [8:0]  CLOSED_MSTEP_DIV  = 9'h100;
	// Reset values
	localparam logic        CLOSED_LOOP_RST   = 1'b0;
	localparam logic        FAULT_FLAG_RST    = 1'b0;
	// Clock and typical settle time
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          SETTLE_TYP_MS     = 50;
	localparam int          SETTLE_TYP_CYC    = SETTLE_TYP_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          MS_CYCLES         = 1000000 / CLK_PERIOD_NS;
	// Quadrature step decode
	localparam logic [1:0]  QDIR_NONE         = 2'h0;
	localparam logic [1:0]  QDIR_UP           = 2'h1;
	localparam logic [1:0]  QDIR_DOWN         = 2'h2;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_MOVE   = 6'h02,
		ST_DRAIN  = 6'h04,
		ST_SETTLE = 6'h08,
		ST_HOLD   = 6'h10,
		ST_HALT   = 6'h20
	} eclsm_state_t;
endpackage : eclsm_pkg

//--- hdl/eclsm_quad.sv
`timescale 1ns/100ps
module eclsm_quad #(
	parameter int POS_W = 32
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Encoder pins
	input  wire logic             enc_a,
	input  wire logic             enc_b,
	// Position
	output logic signed [POS_W-1:0] enc_pos,
	output logic                  enc_tick
);
	typedef struct packed {
		logic [1:0]              sa;
		logic [1:0]              sb;
		logic [1:0]              prev;
		logic signed [POS_W-1:0] pos;
		logic                    tick;
	} eclsm_quad_st_t;

	eclsm_quad_st_t st_ff;
	eclsm_quad_st_t nxt_st;

	function automatic logic [1:0] qdir(input logic [1:0] p, input logic [1:0] c);
		case ({p, c})
			4'h1, 4'h7, 4'he, 4'h8: qdir = eclsm_pkg::QDIR_UP;
			4'h2, 4'hb, 4'hd, 4'h4: qdir = eclsm_pkg::QDIR_DOWN;
			default:                qdir = eclsm_pkg::QDIR_NONE;
		endcase
	endfunction : qdir

	logic [1:0] cur;
	logic [1:0] dir;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sa = {st_ff.sa[0], enc_a};
		nxt_st.sb = {st_ff.sb[0], enc_b};
		cur = {st_ff.sa[1], st_ff.sb[1]};
		dir = qdir(st_ff.prev, cur);
		nxt_st.prev = cur;
		nxt_st.tick = 1'b0;
		// Every edge of either channel is one count
		if (dir == eclsm_pkg::QDIR_UP) begin
			nxt_st.pos = st_ff.pos + POS_W'(1);
			nxt_st.tick = 1'b1;
		end else if (dir == eclsm_pkg::QDIR_DOWN) begin
			nxt_st.pos = st_ff.pos - POS_W'(1);
			nxt_st.tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign enc_pos = st_ff.pos;
	assign enc_tick = st_ff.tick;
endmodule : eclsm_quad

//--- hdl/eclsm_top.sv
`timescale 1ns/100ps
// Behaviour
// - Encoder decoded in quadrature, four counts per line.
// - Closed-loop enable bit, off after reset.
// - Closed loop: move distances taken as encoder counts.
// - Closed loop: run speed value taken as counts per second.
// - Closed loop: microstep divisor forced to 256, writes ignored.
// - Closed loop: move complete only when position within window of target.
// - Closed loop: after all steps issued, wait for position confirmed in window.
// - Closed loop only: step versus count difference over limit raises fault.
// - Stalled encoder: keep stepping to last position plus limit, then flag.
// - Fault halts motion when policy 0, continues when policy 1.
// - Fault flag sticky on every closed-loop stall; cleared by writing zero.
// - Position restoration applied only after a move completes.
// - Restore with policy 1 regardless of limit.
// - Finished move switches run current to idle current; in closed loop only if the idle delay ends after the drain.
// - Idle current switch delayed by programmable delay after last step.
// - Programmable settle delay before checking encoder position.
module eclsm_top #(
	parameter int POS_W = 32,
	parameter int DLY_W = 32
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	// Encoder pins
	input  wire logic                    enc_a,
	input  wire logic                    enc_b,
	// Configuration
	input  wire logic                    closed_loop_wr,
	input  wire logic                    closed_loop_val,
	input  wire logic [POS_W-1:0]        completion_window,
	input  wire logic [POS_W-1:0]        following_error_limit,
	input  wire logic                    fault_stop_policy,
	input  wire logic                    hold_position_servo,
	input  wire logic [7:0]              run_current,
	input  wire logic [7:0]              idle_current,
	input  wire logic [DLY_W-1:0]        idle_current_delay,
	input  wire logic [DLY_W-1:0]        settle_delay,
	input  wire logic                    microstep_wr,
	input  wire logic [8:0]              microstep_val,
	// Fault flag clear
	input  wire logic                    fault_flag_wr,
	input  wire logic                    fault_flag_val,
	// Commands
	input  wire logic                    relative_move,
	input  wire logic                    absolute_move,
	input  wire logic signed [POS_W-1:0] move_distance,
	input  wire logic                    constant_velocity_run,
	input  wire logic [POS_W-1:0]        run_speed,
	input  wire logic                    stop_run,
	// Step generator feedback
	input  wire logic                    step_issued,
	input  wire logic                    step_dir_up,
	// Outputs
	output logic                         closed_loop_on,
	output logic [8:0]                   microstep_divisor,
	output logic                         step_req,
	output logic                         step_req_up,
	output logic [POS_W-1:0]             step_rate,
	output logic                         step_rate_counts,
	output logic                         distance_counts,
	output logic signed [POS_W-1:0]      target_pos,
	output logic signed [POS_W-1:0]      commanded_pos,
	output logic signed [POS_W-1:0]      encoder_pos,
	output logic                         overrun_fault_flag,
	output logic                         move_busy,
	output logic                         move_done,
	output logic [7:0]                   current_setting
);
	typedef struct packed {
		logic                    ca;
		logic                    cb;
		logic                    cl;
		logic [8:0]              msd;
		eclsm_pkg::eclsm_state_t fsm;
		logic signed [POS_W-1:0] tgt;
		logic signed [POS_W-1:0] cmd;
		logic signed [POS_W-1:0] goal;
		logic                    rst_mv;
		logic                    running;
		logic [POS_W-1:0]        rate;
		logic                    flag;
		logic                    exceeded;
		logic                    idle_cur;
		logic                    done;
	} eclsm_top_st_t;

	eclsm_top_st_t st_ff;
	eclsm_top_st_t nxt_st;

	logic signed [POS_W-1:0] enc_pos;
	logic                    enc_tick;
	logic                    settle_start;
	logic                    settle_busy;
	logic                    settle_done;
	logic                    idle_start;
	logic                    idle_busy;
	logic                    idle_done;
	logic signed [POS_W-1:0] err;
	logic [POS_W-1:0]        abs_err;
	logic [POS_W-1:0]        abs_tgt_err;
	logic                    in_window;
	logic                    over_limit;
	logic                    step_left;
	logic signed [POS_W-1:0] cmd_nxt;
	logic signed [POS_W-1:0] offs;
	logic                    restore_ok;

	function automatic logic [POS_W-1:0] mag(input logic signed [POS_W-1:0] v);
		mag = v[POS_W-1] ? POS_W'(-v) : v;
	endfunction : mag

	// Pins pass two flip-flops inside the decoder
	eclsm_quad #(.POS_W(POS_W)) u_quad (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.enc_a    (enc_a),
		.enc_b    (enc_b),
		.enc_pos  (enc_pos),
		.enc_tick (enc_tick)
	);

	eclsm_delay #(.CNT_W(DLY_W)) u_settle (
		.sys_clk (sys_clk),
		.reset   (reset),
		.start   (settle_start),
		.length  (settle_delay),
		.busy    (settle_busy),
		.done    (settle_done)
	);

	eclsm_delay #(.CNT_W(DLY_W)) u_idle (
		.sys_clk (sys_clk),
		.reset   (reset),
		.start   (idle_start),
		.length  (idle_current_delay),
		.busy    (idle_busy),
		.done    (idle_done)
	);

	always_comb begin
		// Commanded position follows issued steps
		cmd_nxt = st_ff.cmd;
		if (step_issued) begin
			cmd_nxt = step_dir_up ? st_ff.cmd + POS_W'(1) : st_ff.cmd - POS_W'(1);
		end
		// Judged on the step that would pass the limit
		err = cmd_nxt - enc_pos;
		abs_err = mag(err);
		abs_tgt_err = mag(enc_pos - st_ff.tgt);
		in_window = (abs_tgt_err <= completion_window);
		over_limit = st_ff.cl && (abs_err > following_error_limit);
		step_left = (st_ff.cmd != st_ff.goal) || st_ff.running;
		// Step goal carries the step to count offset
		offs = st_ff.cmd - enc_pos;
		restore_ok = st_ff.cl && hold_position_servo && (fault_stop_policy || !st_ff.exceeded);
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ca = 1'b0;
		nxt_st.cb = 1'b0;
		nxt_st.done = 1'b0;
		settle_start = 1'b0;
		idle_start = 1'b0;
		// Mode bit and divisor lock
		if (closed_loop_wr) begin
			nxt_st.cl = closed_loop_val;
		end
		if (nxt_st.cl) begin
			nxt_st.msd = eclsm_pkg::CLOSED_MSTEP_DIV;
		end else if (microstep_wr) begin
			nxt_st.msd = microstep_val;
		end
		nxt_st.cmd = cmd_nxt;
		// Fault flag: software writes zero, stall set wins
		if (fault_flag_wr && !fault_flag_val) begin
			nxt_st.flag = 1'b0;
		end
		case (st_ff.fsm)
			eclsm_pkg::ST_IDLE, eclsm_pkg::ST_HOLD: begin
				if (relative_move || absolute_move) begin
					// Distances in counts when closed loop, microsteps otherwise
					nxt_st.tgt = relative_move ? st_ff.tgt + move_distance : move_distance;
					nxt_st.goal = nxt_st.tgt + (st_ff.cl ? offs : POS_W'(0));
					nxt_st.rst_mv = 1'b0;
					nxt_st.exceeded = 1'b0;
					nxt_st.idle_cur = 1'b0;
					nxt_st.fsm = eclsm_pkg::ST_MOVE;
				end else if (constant_velocity_run) begin
					nxt_st.rate = run_speed;
					nxt_st.running = 1'b1;
					nxt_st.rst_mv = 1'b0;
					nxt_st.idle_cur = 1'b0;
					nxt_st.fsm = eclsm_pkg::ST_MOVE;
				end else if (st_ff.fsm == eclsm_pkg::ST_HOLD && !in_window && !settle_busy) begin
					// Restore only after completion
					if (restore_ok) begin
						nxt_st.goal = st_ff.tgt + offs;
						nxt_st.rst_mv = 1'b1;
						nxt_st.idle_cur = 1'b0;
						nxt_st.fsm = eclsm_pkg::ST_MOVE;
					end
				end
				if (st_ff.fsm == eclsm_pkg::ST_HOLD && !hold_position_servo) begin
					nxt_st.fsm = (nxt_st.fsm == eclsm_pkg::ST_MOVE) ? eclsm_pkg::ST_MOVE : eclsm_pkg::ST_IDLE;
				end
			end
			eclsm_pkg::ST_MOVE: begin
				if (stop_run) begin
					nxt_st.running = 1'b0;
					nxt_st.goal = cmd_nxt;
					nxt_st.tgt = cmd_nxt + (st_ff.tgt - st_ff.goal);
				end
				// Checked on every encoder update or issued step in ST_MOVE, not in ST_DRAIN
				if (enc_tick || step_issued) begin
					if (over_limit) begin
						nxt_st.flag = 1'b1;
						nxt_st.exceeded = 1'b1;
						if (!fault_stop_policy) begin
							nxt_st.running = 1'b0;
							nxt_st.tgt = cmd_nxt;
							nxt_st.goal = cmd_nxt;
							nxt_st.fsm = eclsm_pkg::ST_HALT;
						end
					end
				end
				if (!step_left && nxt_st.fsm == eclsm_pkg::ST_MOVE) begin
					idle_start = 1'b1;
					settle_start = 1'b1;
					nxt_st.fsm = st_ff.cl ? eclsm_pkg::ST_DRAIN : eclsm_pkg::ST_HOLD;
					nxt_st.done = !st_ff.cl;
				end
			end
			eclsm_pkg::ST_DRAIN: begin
				// All steps out: wait settle, then confirm window
				if (!settle_busy && !settle_start && in_window) begin
					nxt_st.done = 1'b1;
					nxt_st.fsm = eclsm_pkg::ST_HOLD;
				end else if (!settle_busy && !settle_start && st_ff.rst_mv && restore_ok) begin
					// Restoring move still out of window: retry
					nxt_st.goal = st_ff.tgt + offs;
					nxt_st.fsm = eclsm_pkg::ST_MOVE;
				end
			end
			eclsm_pkg::ST_HALT: begin
				nxt_st.fsm = eclsm_pkg::ST_IDLE;
				idle_start = 1'b1;
			end
			default: begin
				nxt_st.fsm = eclsm_pkg::ST_IDLE;
			end
		endcase
		// Idle current after the delay past the last step
		if (idle_done && nxt_st.fsm != eclsm_pkg::ST_MOVE && nxt_st.fsm != eclsm_pkg::ST_DRAIN) begin
			nxt_st.idle_cur = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.cl <= eclsm_pkg::CLOSED_LOOP_RST;
			st_ff.msd <= eclsm_pkg::CLOSED_MSTEP_DIV;
			st_ff.fsm <= eclsm_pkg::ST_IDLE;
			st_ff.flag <= eclsm_pkg::FAULT_FLAG_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign closed_loop_on = st_ff.cl;
	assign microstep_divisor = st_ff.msd;
	assign step_req = (st_ff.fsm == eclsm_pkg::ST_MOVE) && step_left;
	assign step_req_up = st_ff.running ? 1'b1 : (st_ff.goal > st_ff.cmd);
	assign step_rate = st_ff.rate;
	assign step_rate_counts = st_ff.cl;
	assign distance_counts = st_ff.cl;
	assign target_pos = st_ff.tgt;
	assign commanded_pos = st_ff.cmd;
	assign encoder_pos = enc_pos;
	assign overrun_fault_flag = st_ff.flag;
	assign move_busy = (st_ff.fsm == eclsm_pkg::ST_MOVE) || (st_ff.fsm == eclsm_pkg::ST_DRAIN);
	assign move_done = st_ff.done;
	assign current_setting = st_ff.idle_cur ? idle_current : run_current;
endmodule : eclsm_top

//--- test/eclsm_motor_model.sv
`timescale 1ns/100ps
module eclsm_motor_model #(
	parameter int GAP = 3
) (
	// Clock
	input  wire logic               sys_clk,
	// Step side
	input  wire logic               step_req,
	input  wire logic               step_req_up,
	output logic                    step_issued,
	output logic                    step_dir_up,
	// Load side
	input  wire logic               jam,
	input  wire logic signed [15:0] push,
	output logic                    enc_a,
	output logic                    enc_b
);
	int shaft = 0;
	int enc   = 0;
	int gap   = 0;
	initial begin
		step_issued = 1'b0;
		step_dir_up = 1'b1;
	end
	// Steps at fixed spacing while requested
	always @(posedge sys_clk) begin
		#1;
		step_issued = 1'b0;
		gap = gap + 1;
		if (step_req && gap >= GAP) begin
			gap = 0;
			step_issued = 1'b1;
			step_dir_up = step_req_up;
			shaft = shaft + (step_req_up ? 1 : -1);
		end
		// Encoder chases shaft plus displacement unless jammed
		if (!jam && enc < shaft + push)
			enc = enc + 1;
		else if (!jam && enc > shaft + push)
			enc = enc - 1;
	end
	// Quadrature, B leads A counting up, one count per edge
	assign enc_a = enc[1];
	assign enc_b = enc[1] ^ enc[0];
endmodule : eclsm_motor_model

//--- test/eclsm_top_properties.sv
`timescale 1ns/100ps
module eclsm_top_properties #(
	parameter int POS_W = 32,
	parameter int DLY_W = 32
) (
	// Clock and reset
	input wire logic                    sys_clk,
	input wire logic                    reset,
	// Watched ports
	input wire logic                    closed_loop_on,
	input wire logic [8:0]              microstep_divisor,
	input wire logic                    step_rate_counts,
	input wire logic                    distance_counts,
	input wire logic                    fault_flag_wr,
	input wire logic                    fault_stop_policy,
	input wire logic                    overrun_fault_flag,
	input wire logic                    move_busy,
	input wire logic                    move_done,
	input wire logic [7:0]              run_current,
	input wire logic [7:0]              current_setting,
	input wire logic [POS_W-1:0]        completion_window,
	input wire logic signed [POS_W-1:0] target_pos,
	input wire logic signed [POS_W-1:0] encoder_pos
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic win_ok;
	// Encoder inside the window on both sides
	assign win_ok = ($signed(encoder_pos - target_pos) <= $signed(completion_window))
		&& ($signed(target_pos - encoder_pos) <= $signed(completion_window));
	chk_reset_values: assert property (disable iff (1'b0) reset |=> !closed_loop_on && !overrun_fault_flag)
		else $error("reset values wrong");
	chk_divisor_locked: assert property (closed_loop_on |-> microstep_divisor == 9'h100)
		else $error("divisor not locked");
	chk_units_follow: assert property (distance_counts == closed_loop_on && step_rate_counts == closed_loop_on)
		else $error("units select wrong");
	chk_fault_closed_only: assert property ($rose(overrun_fault_flag) |-> $past(closed_loop_on))
		else $error("fault outside closed loop");
	chk_flag_sticky: assert property (overrun_fault_flag && !fault_flag_wr |=> overrun_fault_flag)
		else $error("fault flag dropped");
	chk_halt_on_fault: assert property ($rose(overrun_fault_flag) && !fault_stop_policy |-> ##[0:3] !move_busy)
		else $error("no halt on fault");
	chk_done_window: assert property (move_done && closed_loop_on |-> win_ok)
		else $error("done outside window");
	chk_done_pulse: assert property (move_done |=> !move_done)
		else $error("done longer than a cycle");
	chk_run_current: assert property (move_busy [*2] |-> current_setting == run_current)
		else $error("idle current during move");
endmodule : eclsm_top_properties

bind eclsm_top eclsm_top_properties #(.POS_W(POS_W), .DLY_W(DLY_W)) u_chk (.*);

//--- test/test_encoder_closed_loop_stall_monitor.sv
`timescale 1ns/100ps
module test_encoder_closed_loop_stall_monitor;
	logic sys_clk = 1'b0;
	logic reset, enc_a, enc_b, closed_loop_wr, closed_loop_val, fault_stop_policy, hold_position_servo, jam;
	logic microstep_wr, fault_flag_wr, fault_flag_val, relative_move, absolute_move, constant_velocity_run, stop_run;
	logic step_issued, step_dir_up, closed_loop_on, step_req, step_req_up, step_rate_counts, distance_counts;
	logic overrun_fault_flag, move_busy, move_done;
	logic [31:0]        completion_window, following_error_limit, idle_current_delay, settle_delay, run_speed, step_rate;
	logic [7:0]         run_current, idle_current, current_setting;
	logic [8:0]         microstep_val, microstep_divisor;
	logic signed [31:0] move_distance, target_pos, commanded_pos, encoder_pos, base, diff;
	logic signed [15:0] push;
	int                 err_count = 0;
	int                 checks = 0;
	int                 i;

	always #5 sys_clk = ~sys_clk;
	eclsm_top DUT (.*);
	eclsm_motor_model u_motor (.*);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask : pulse
	task automatic move(input logic is_abs, input logic signed [31:0] d);
		move_distance = d;
		if (is_abs)
			pulse(absolute_move);
		else
			pulse(relative_move);
	endtask : move
	task automatic wait_done();
		for (i = 0; i < 5000 && move_done !== 1'b1; i++)
			tick(1);
		check(move_done, 1'b1);
	endtask : wait_done
	task automatic wait_flag();
		for (i = 0; i < 2000 && overrun_fault_flag !== 1'b1; i++)
			tick(1);
	endtask : wait_flag
	task automatic end_of_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		#900_000;
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		{reset, closed_loop_wr, closed_loop_val, fault_stop_policy, hold_position_servo, jam} = 6'b10_0000;
		{microstep_wr, fault_flag_wr, fault_flag_val, relative_move, absolute_move, constant_velocity_run} = '0;
		stop_run = 1'b0;
		{completion_window, following_error_limit} = {32'h0000_0002, 32'h0000_0005};
		{idle_current_delay, settle_delay, run_speed} = {32'h0000_0014, 32'h0000_000a, 32'h0000_0000};
		{run_current, idle_current, microstep_val, move_distance, push} = '0;
		run_current = 8'hc8;
		idle_current = 8'h32;
		tick(6);
		reset = 1'b0;
		tick(4);
		check(closed_loop_on, 1'b0);
		check(microstep_divisor, 9'h100);
		// Open loop: divisor writable, no fault with the encoder jammed
		microstep_val = 9'h080;
		pulse(microstep_wr);
		check(microstep_divisor, 9'h080);
		check(distance_counts, 1'b0);
		jam = 1'b1;
		move(1'b0, 32'sh0000_000c);
		wait_done();
		check(overrun_fault_flag, 1'b0);
		jam = 1'b0;
		tick(40);
		check(encoder_pos, 32'h0000_000c);
		// Closed loop on, divisor locked
		closed_loop_val = 1'b1;
		pulse(closed_loop_wr);
		check(closed_loop_on, 1'b1);
		check(microstep_divisor, 9'h100);
		microstep_val = 9'h020;
		pulse(microstep_wr);
		check(microstep_divisor, 9'h100);
		check({distance_counts, step_rate_counts}, 2'b11);
		// Absolute move in counts, then idle current
		move(1'b1, 32'sh0000_0034);
		check(current_setting, run_current);
		wait_done();
		check(target_pos, 32'h0000_0034);
		check(encoder_pos, 32'h0000_0034);
		tick(25);
		check(current_setting, idle_current);
		// Stall with halt policy
		move(1'b0, 32'sh0000_0028);
		tick(30);
		jam = 1'b1;
		wait_flag();
		check(overrun_fault_flag, 1'b1);
		tick(4);
		check(move_busy, 1'b0);
		diff = commanded_pos - encoder_pos;
		check(diff >= 32'sh0000_0005 && diff <= 32'sh0000_0006, 1'b1);
		jam = 1'b0;
		tick(30);
		check(overrun_fault_flag, 1'b1);
		pulse(fault_flag_wr);
		check(overrun_fault_flag, 1'b0);
		// Stall with continue policy and restoration on
		fault_stop_policy = 1'b1;
		hold_position_servo = 1'b1;
		base = u_motor.shaft;
		move(1'b0, 32'sh0000_0028);
		tick(30);
		jam = 1'b1;
		wait_flag();
		tick(4);
		check(move_busy, 1'b1);
		jam = 1'b0;
		wait_done();
		check(target_pos, base + 32'sh0000_0028);
		check(overrun_fault_flag, 1'b1);
		tick(20);
		push = 16'sh000a;
		for (i = 0; i < 200 && move_busy !== 1'b1; i++)
			tick(1);
		check(move_busy, 1'b1);
		for (i = 0; i < 3000 && move_busy !== 1'b0; i++)
			tick(1);
		diff = encoder_pos - (base + 32'sh0000_0028);
		check(diff >= -32'sh0000_0002 && diff <= 32'sh0000_0002, 1'b1);
		// Constant velocity run in counts per second
		run_speed = 32'h0000_36b0;
		pulse(constant_velocity_run);
		tick(2);
		check(step_rate, 32'h0000_36b0);
		check(move_busy, 1'b1);
		pulse(stop_run);
		tick(20);
		end_of_test();
	end
endmodule : test_encoder_closed_loop_stall_monitor
